// [rtl/fct_pkg.sv]
// Shared types and constants of the float coprocessor issue and timing block.
// Assumes one clock domain shared with the dispatching integer core and the arithmetic datapath.
package fct_pkg;

  localparam int FCT_NREG   = 32;
  localparam int FCT_RA_W   = 5;
  localparam int FCT_DATA_W = 64;
  localparam int FCT_TAG_W  = 8;
  localparam int FCT_CNT_W  = 6;
  localparam int FCT_CCR_W  = 9;
  localparam int FCT_QDEPTH = 2;

  // Condition/control register: condition flags in the low byte, flush-to-zero above them.
  localparam int                   FCT_CCR_FTZ_BIT = 8;
  localparam logic [FCT_CCR_W-1:0] FCT_CCR_RST     = 9'h000;
  localparam logic                 FCT_FR64_RST    = 1'h1;

  // Latency and repeat counts, in coprocessor clock cycles.
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_BASIC  = 6'h04;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_BASIC  = 6'h01;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_MULD   = 6'h05;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_MULD   = 6'h02;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_RCP_S  = 6'h0D;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_RCP_S  = 6'h0A;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_RCP_D  = 6'h1A;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_RCP_D  = 6'h15;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_RSQ_S  = 6'h11;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_RSQ_S  = 6'h0E;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_RSQ_D  = 6'h24;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_RSQ_D  = 6'h1F;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_DIV_S  = 6'h11;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_DIV_S  = 6'h0E;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_DIV_D  = 6'h20;
  localparam logic [FCT_CNT_W-1:0] FCT_REP_DIV_D  = 6'h1D;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_LOAD   = 6'h04;
  localparam logic [FCT_CNT_W-1:0] FCT_LAT_STORE  = 6'h01;

  typedef enum logic [4:0] {
    FCT_OP_ABS, FCT_OP_NEG, FCT_OP_MOV, FCT_OP_MOVF, FCT_OP_MOVT, FCT_OP_MOVZ, FCT_OP_MOVN,
    FCT_OP_ARITH, FCT_OP_CMP, FCT_OP_MULD, FCT_OP_RECIP, FCT_OP_RSQRT, FCT_OP_DIVSQ,
    FCT_OP_LOAD, FCT_OP_STORE, FCT_OP_CTRL_WR
  } fct_op_t;

  typedef struct packed {
    fct_op_t                 op;
    logic [5:0]              func;
    logic                    dbl;
    logic [FCT_RA_W-1:0]     dst;
    logic [FCT_RA_W-1:0]     src_a;
    logic [FCT_RA_W-1:0]     src_b;
    logic [FCT_RA_W-1:0]     src_c;
    logic [2:0]              cc_sel;
    logic [FCT_DATA_W-1:0]   ival;
    logic [FCT_TAG_W-1:0]    tag;
  } fct_req_t;

  typedef struct packed {
    logic                    valid;
    fct_op_t                 op;
    logic [5:0]              func;
    logic                    dbl;
    logic [FCT_RA_W-1:0]     dst;
    logic [FCT_DATA_W-1:0]   a;
    logic [FCT_DATA_W-1:0]   b;
    logic [FCT_DATA_W-1:0]   c;
    logic [FCT_TAG_W-1:0]    tag;
  } fct_ex_t;

  typedef struct packed {
    logic                    valid;
    logic                    is_cmp;
    logic                    dbl;
    logic [FCT_RA_W-1:0]     dst;
    logic [FCT_DATA_W-1:0]   data;
    logic                    denorm;
    logic                    except;
    logic [FCT_TAG_W-1:0]    tag;
  } fct_ret_t;

  function automatic logic [FCT_CNT_W-1:0] fct_lat(input fct_op_t op, input logic dbl);
    case (op)
      FCT_OP_MULD:  fct_lat = dbl ? FCT_LAT_MULD : FCT_LAT_BASIC;
      FCT_OP_RECIP: fct_lat = dbl ? FCT_LAT_RCP_D : FCT_LAT_RCP_S;
      FCT_OP_RSQRT: fct_lat = dbl ? FCT_LAT_RSQ_D : FCT_LAT_RSQ_S;
      FCT_OP_DIVSQ: fct_lat = dbl ? FCT_LAT_DIV_D : FCT_LAT_DIV_S;
      FCT_OP_LOAD:  fct_lat = FCT_LAT_LOAD;
      FCT_OP_STORE: fct_lat = FCT_LAT_STORE;
      default:      fct_lat = FCT_LAT_BASIC;
    endcase
  endfunction

  function automatic logic [FCT_CNT_W-1:0] fct_rep(input fct_op_t op, input logic dbl);
    case (op)
      FCT_OP_MULD:  fct_rep = dbl ? FCT_REP_MULD : FCT_REP_BASIC;
      FCT_OP_RECIP: fct_rep = dbl ? FCT_REP_RCP_D : FCT_REP_RCP_S;
      FCT_OP_RSQRT: fct_rep = dbl ? FCT_REP_RSQ_D : FCT_REP_RSQ_S;
      FCT_OP_DIVSQ: fct_rep = dbl ? FCT_REP_DIV_D : FCT_REP_DIV_S;
      default:      fct_rep = FCT_REP_BASIC;
    endcase
  endfunction

endpackage

// [rtl/fct_core.sv]
// Float coprocessor issue, interlock, writeback and register bank.
// Assumes the dispatching core, the arithmetic datapath and this block share i_clk;
// the datapath performs the IEEE arithmetic and answers each request exactly on time.
// Functional notes
// [RULE1] Single and double IEEE binary formats are carried through the whole block.
// [RULE2] Thirty-two registers, 64-bit wide or 32-bit wide paired for doubles, by mode.
// [RULE3] Fused multiply-add rounds the product first, matching separate multiply then add.
// [RULE4] Denormal results become signed zero when flush-to-zero is set, else fault.
// [RULE5] The float pipeline advances every cycle, independent of integer stalls.
// [RULE6] Arithmetic issues and completes strictly in program order.
// [RULE7] Stores may finish early; all dependencies are still honoured.
// [RULE8] Faults are precise: later results are discarded and issue stops.
// [RULE9] Latency counts cycles to dependent use; repeat counts cycles between issues.
// [RULE10] Abs, negate, add, subtract, compare, single multiply: latency four, repeat one.
// [RULE11] Single multiply-add forms and absolute compares: latency four, repeat one.
// [RULE12] Format conversions including ceiling, floor, round, truncate: four and one.
// [RULE13] Moves and conditional moves: latency four, repeat one.
// [RULE14] Double multiply and double multiply-add forms: latency five, repeat two.
// [RULE15] Reciprocal, inverse root, divide, root take the tabled latency and repeat.
// [RULE16] Integer or memory into float register: latency four, repeat one.
// [RULE17] Float register to integer or memory: latency one, repeat one.
// [RULE18] Issue holds until sources are ready and the unit's repeat interval passed.
`timescale 1ns/10ps
module fct_core (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst,
  input  wire logic                             i_req_valid,
  input  wire fct_pkg::fct_req_t                i_req,
  output logic                                  o_req_ready,
  input  wire logic                             i_fr64,
  input  wire logic                             i_fault_clear,
  input  wire fct_pkg::fct_ret_t                i_ret,
  output fct_pkg::fct_ex_t                      o_ex,
  output logic                                  o_out_valid,
  output logic [fct_pkg::FCT_DATA_W-1:0]        o_out_data,
  output logic [fct_pkg::FCT_TAG_W-1:0]         o_out_tag,
  output logic                                  o_fault,
  output logic [fct_pkg::FCT_TAG_W-1:0]         o_fault_tag,
  output logic [fct_pkg::FCT_CCR_W-1:0]         o_ccr,
  output logic                                  o_busy
);
  import fct_pkg::*;

  fct_req_t                q_r [FCT_QDEPTH];
  logic [1:0]              qcnt_r;
  logic [1:0]              qcnt_nxt;
  logic [1:0]              widx;
  logic                    req_ready_r;
  logic [FCT_CNT_W-1:0]    rc_r [FCT_NREG];
  logic [FCT_DATA_W-1:0]   rf_r [FCT_NREG];
  logic [FCT_CNT_W-1:0]    order_r;
  logic [FCT_CNT_W-1:0]    rep_mul_r;
  logic [FCT_CNT_W-1:0]    rep_div_r;
  logic [FCT_CNT_W-1:0]    cc_cnt_r;
  logic [FCT_CCR_W-1:0]    ccr_r;
  logic                    fr64_r;
  logic                    fault_r;
  logic [FCT_TAG_W-1:0]    fault_tag_r;
  fct_ex_t                 ex_r;
  logic                    out_valid_r;
  logic [FCT_DATA_W-1:0]   out_data_r;
  logic [FCT_TAG_W-1:0]    out_tag_r;
  logic                    busy_r;
  // Internal results travel three stages so they land exactly four cycles after issue.
  logic                    pv_r [3];
  logic                    pdbl_r [3];
  logic [FCT_RA_W-1:0]     pdst_r [3];
  logic [FCT_DATA_W-1:0]   pdat_r [3];

  fct_req_t                h;
  logic [FCT_CNT_W-1:0]    lat;
  logic [FCT_CNT_W-1:0]    rep;
  logic                    is_ext;
  logic                    is_div;
  logic                    writes_fp;
  logic                    ordered;
  logic                    pair;
  logic                    src_ok;
  logic                    go;
  logic                    take;
  logic [FCT_DATA_W-1:0]   a_val;
  logic [FCT_DATA_W-1:0]   b_val;
  logic [FCT_DATA_W-1:0]   c_val;
  logic [FCT_DATA_W-1:0]   d_val;
  logic [FCT_DATA_W-1:0]   int_res;
  logic                    sgn;
  logic                    flt_ev;
  logic                    wb_v;
  logic                    wb_dbl;
  logic [FCT_RA_W-1:0]     wb_dst;
  logic [FCT_DATA_W-1:0]   wb_data;
  logic                    cmp_wb;

  function automatic logic pair_ok(input logic [FCT_CNT_W-1:0] lo, input logic [FCT_CNT_W-1:0] hi,
                                   input logic p);
    pair_ok = (lo <= 6'h01) && (!p || (hi <= 6'h01));
  endfunction

  function automatic logic [FCT_RA_W-1:0] odd(input logic [FCT_RA_W-1:0] r);
    odd = {r[FCT_RA_W-1:1], 1'b1};
  endfunction

  function automatic logic [FCT_RA_W-1:0] even(input logic [FCT_RA_W-1:0] r);
    even = {r[FCT_RA_W-1:1], 1'b0};
  endfunction

  // [RULE2] Paired reads in narrow mode.
  function automatic logic [FCT_DATA_W-1:0] rd(input logic [FCT_RA_W-1:0] r, input logic p,
                                               input logic [FCT_DATA_W-1:0] lo,
                                               input logic [FCT_DATA_W-1:0] hi);
    rd = p ? {hi[31:0], lo[31:0]} : lo;
  endfunction

  assign h         = q_r[0];
  assign take      = i_req_valid && req_ready_r;
  assign pair      = !fr64_r && h.dbl;
  assign is_div    = (h.op == FCT_OP_RECIP) || (h.op == FCT_OP_RSQRT) || (h.op == FCT_OP_DIVSQ);
  assign is_ext    = (h.op == FCT_OP_ARITH) || (h.op == FCT_OP_CMP) || (h.op == FCT_OP_MULD) || is_div;
  assign writes_fp = (h.op != FCT_OP_STORE) && (h.op != FCT_OP_CTRL_WR) && (h.op != FCT_OP_CMP);
  assign ordered   = (h.op != FCT_OP_STORE) && (h.op != FCT_OP_CTRL_WR);
  assign sgn       = h.dbl ? a_val[63] : a_val[31];

  // [RULE9] [RULE10] [RULE11] [RULE12] Per-class latency and repeat.
  always_comb begin
    lat = fct_lat(h.op, h.dbl);
    rep = fct_rep(h.op, h.dbl);
  end

  always_comb begin
    a_val = rd(h.src_a, pair, rf_r[pair ? even(h.src_a) : h.src_a], rf_r[odd(h.src_a)]);
    b_val = rd(h.src_b, pair, rf_r[pair ? even(h.src_b) : h.src_b], rf_r[odd(h.src_b)]);
    c_val = rd(h.src_c, pair, rf_r[pair ? even(h.src_c) : h.src_c], rf_r[odd(h.src_c)]);
    d_val = rd(h.dst, pair, rf_r[pair ? even(h.dst) : h.dst], rf_r[odd(h.dst)]);
  end

  // [RULE18] Source, condition, unit and order interlock.
  always_comb begin
    src_ok = 1'b1;
    if ((h.op != FCT_OP_LOAD) && (h.op != FCT_OP_CTRL_WR) &&
        (h.op != FCT_OP_MOVZ) && (h.op != FCT_OP_MOVN)) begin
      src_ok = pair_ok(rc_r[pair ? even(h.src_a) : h.src_a], rc_r[odd(h.src_a)], pair);
    end
    if ((h.op == FCT_OP_MOVZ) || (h.op == FCT_OP_MOVN)) begin
      src_ok = pair_ok(rc_r[pair ? even(h.src_a) : h.src_a], rc_r[odd(h.src_a)], pair);
    end
    if (is_ext) begin
      src_ok = src_ok && pair_ok(rc_r[pair ? even(h.src_b) : h.src_b], rc_r[odd(h.src_b)], pair)
                      && pair_ok(rc_r[pair ? even(h.src_c) : h.src_c], rc_r[odd(h.src_c)], pair);
    end
    // Conditional moves keep the old destination, so it must be settled first.
    if ((h.op == FCT_OP_MOVF) || (h.op == FCT_OP_MOVT) || (h.op == FCT_OP_MOVZ) || (h.op == FCT_OP_MOVN)) begin
      src_ok = src_ok && pair_ok(rc_r[pair ? even(h.dst) : h.dst], rc_r[odd(h.dst)], pair);
    end
    if ((h.op == FCT_OP_MOVF) || (h.op == FCT_OP_MOVT)) begin
      src_ok = src_ok && (cc_cnt_r <= 6'h01);
    end
    go = (qcnt_r != 2'h0) && !fault_r && src_ok;
    // [RULE14] Double multiply unit repeat.
    if ((h.op == FCT_OP_MULD) && h.dbl && (rep_mul_r > 6'h01)) begin
      go = 1'b0;
    end
    // [RULE15] Divider repeat interval.
    if (is_div && (rep_div_r > 6'h01)) begin
      go = 1'b0;
    end
    // [RULE6] In-order completion of writers.
    if (ordered && (lat < order_r)) begin
      go = 1'b0;
    end
    // [RULE8] Stores wait for older writers so a fault cannot leak.
    if (!ordered && (order_r > 6'h01)) begin
      go = 1'b0;
    end
  end

  // [RULE1] [RULE13] Sign operations and moves, done locally.
  always_comb begin
    int_res = a_val;
    case (h.op)
      FCT_OP_ABS:  int_res = h.dbl ? {1'b0, a_val[62:0]} : {a_val[63:32], 1'b0, a_val[30:0]};
      FCT_OP_NEG:  int_res = h.dbl ? {~sgn, a_val[62:0]} : {a_val[63:32], ~sgn, a_val[30:0]};
      FCT_OP_MOVF: int_res = ccr_r[h.cc_sel] ? d_val : a_val;
      FCT_OP_MOVT: int_res = ccr_r[h.cc_sel] ? a_val : d_val;
      FCT_OP_MOVZ: int_res = (h.ival == 64'h0) ? a_val : d_val;
      FCT_OP_MOVN: int_res = (h.ival != 64'h0) ? a_val : d_val;
      // [RULE16] Transfer in from integer side or memory.
      FCT_OP_LOAD: int_res = h.ival;
      default:     int_res = a_val;
    endcase
  end

  // [RULE4] Flush-to-zero or fault on denormal.
  always_comb begin
    flt_ev  = i_ret.valid && !fault_r && (i_ret.except || (i_ret.denorm && !ccr_r[FCT_CCR_FTZ_BIT]));
    wb_v    = 1'b0;
    wb_dbl  = pdbl_r[2];
    wb_dst  = pdst_r[2];
    wb_data = pdat_r[2];
    cmp_wb  = 1'b0;
    if (pv_r[2]) begin
      wb_v = !fault_r;
    end
    if (i_ret.valid) begin
      wb_dbl  = i_ret.dbl;
      wb_dst  = i_ret.dst;
      wb_data = i_ret.data;
      if (i_ret.denorm) begin
        wb_data = i_ret.dbl ? {i_ret.data[63], 63'h0} : {32'h0, i_ret.data[31], 31'h0};
      end
      cmp_wb = i_ret.is_cmp && !fault_r && !flt_ev;
      wb_v   = !i_ret.is_cmp && !fault_r && !flt_ev;
    end
  end

  // [RULE6] Dispatch queue keeps program order.
  always_comb begin
    widx     = qcnt_r - {1'b0, go};
    qcnt_nxt = qcnt_r + {1'b0, take} - {1'b0, go};
    if (fault_r || flt_ev) begin
      qcnt_nxt = 2'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r[0]      <= '0;
      q_r[1]      <= '0;
      qcnt_r      <= 2'h0;
      req_ready_r <= 1'b0;
    end else begin
      if (go) begin
        q_r[0] <= q_r[1];
      end
      if (take) begin
        q_r[widx[0]] <= i_req;
      end
      qcnt_r      <= qcnt_nxt;
      req_ready_r <= (qcnt_nxt != 2'h2) && !flt_ev && !(fault_r && !i_fault_clear);
    end
  end

  // [RULE5] Counters run every cycle, whatever the integer side does.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      order_r   <= 6'h00;
      rep_mul_r <= 6'h00;
      rep_div_r <= 6'h00;
      cc_cnt_r  <= 6'h00;
    end else begin
      order_r   <= (go && ordered) ? lat : ((order_r != 6'h00) ? order_r - 6'h01 : order_r);
      rep_mul_r <= (go && (h.op == FCT_OP_MULD) && h.dbl) ? rep :
                   ((rep_mul_r != 6'h00) ? rep_mul_r - 6'h01 : rep_mul_r);
      rep_div_r <= (go && is_div) ? rep : ((rep_div_r != 6'h00) ? rep_div_r - 6'h01 : rep_div_r);
      cc_cnt_r  <= (go && (h.op == FCT_OP_CMP)) ? lat : ((cc_cnt_r != 6'h00) ? cc_cnt_r - 6'h01 : cc_cnt_r);
    end
  end

  // [RULE2] Register bank with readiness counters.
  for (genvar gi = 0; gi < FCT_NREG; gi++) begin : g_reg
    localparam logic [FCT_RA_W-1:0] IDX = FCT_RA_W'(gi);
    logic set_i;
    logic wlo;
    logic whi;
    assign set_i = go && writes_fp && ((IDX == h.dst) || (pair && (IDX[FCT_RA_W-1:1] == h.dst[FCT_RA_W-1:1])));
    assign wlo   = wb_v && (((fr64_r || !wb_dbl) && (IDX == wb_dst)) || (!fr64_r && wb_dbl && (IDX == even(wb_dst))));
    assign whi   = wb_v && !fr64_r && wb_dbl && (IDX == odd(wb_dst));
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        rc_r[gi] <= 6'h00;
      end else if (set_i) begin
        rc_r[gi] <= lat;
      end else if (rc_r[gi] != 6'h00) begin
        rc_r[gi] <= rc_r[gi] - 6'h01;
      end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        rf_r[gi] <= 64'h0;
      end else if (whi) begin
        rf_r[gi] <= {32'h0, wb_data[63:32]};
      end else if (wlo) begin
        rf_r[gi] <= fr64_r ? wb_data : {32'h0, wb_data[31:0]};
      end
    end
  end

  // [RULE13] Local results land four cycles after issue.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 3; k++) begin
        pv_r[k]   <= 1'b0;
        pdbl_r[k] <= 1'b0;
        pdst_r[k] <= 5'h00;
        pdat_r[k] <= 64'h0;
      end
    end else begin
      pv_r[0]   <= go && !is_ext && writes_fp;
      pdbl_r[0] <= h.dbl;
      pdst_r[0] <= h.dst;
      pdat_r[0] <= int_res;
      for (int k = 1; k < 3; k++) begin
        pv_r[k]   <= pv_r[k-1];
        pdbl_r[k] <= pdbl_r[k-1];
        pdst_r[k] <= pdst_r[k-1];
        pdat_r[k] <= pdat_r[k-1];
      end
    end
  end

  // [RULE3] Multiply-add forms go to the datapath as one request with three operands.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ex_r <= '0;
    end else begin
      ex_r.valid <= go && is_ext;
      ex_r.op    <= h.op;
      ex_r.func  <= h.func;
      ex_r.dbl   <= h.dbl;
      ex_r.dst   <= (h.op == FCT_OP_CMP) ? {2'h0, h.cc_sel} : h.dst;
      ex_r.a     <= a_val;
      ex_r.b     <= b_val;
      ex_r.c     <= c_val;
      ex_r.tag   <= h.tag;
    end
  end

  // [RULE7] [RULE17] Transfer out one cycle after issue.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_valid_r <= 1'b0;
      out_data_r  <= 64'h0;
      out_tag_r   <= 8'h00;
    end else begin
      out_valid_r <= go && (h.op == FCT_OP_STORE);
      out_data_r  <= a_val;
      out_tag_r   <= h.tag;
    end
  end

  // Condition flags and flush-to-zero; compare results and control writes never share an edge.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ccr_r <= FCT_CCR_RST;
    end else if (go && (h.op == FCT_OP_CTRL_WR)) begin
      ccr_r <= h.ival[FCT_CCR_W-1:0];
    end else if (cmp_wb) begin
      ccr_r[i_ret.dst[2:0]] <= i_ret.data[0];
    end
  end

  // [RULE8] A new fault wins over a clear in the same cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_r     <= 1'b0;
      fault_tag_r <= 8'h00;
    end else if (flt_ev) begin
      fault_r     <= 1'b1;
      fault_tag_r <= i_ret.tag;
    end else if (i_fault_clear) begin
      fault_r <= 1'b0;
    end
  end

  // Width mode is only taken while idle, since changing it mid-flight would remap live registers.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fr64_r <= FCT_FR64_RST;
      busy_r <= 1'b0;
    end else begin
      if ((qcnt_r == 2'h0) && (order_r <= 6'h01)) begin
        fr64_r <= i_fr64;
      end
      busy_r <= (qcnt_nxt != 2'h0) || (order_r > 6'h01);
    end
  end

  assign o_req_ready = req_ready_r;
  assign o_ex        = ex_r;
  assign o_out_valid = out_valid_r;
  assign o_out_data  = out_data_r;
  assign o_out_tag   = out_tag_r;
  assign o_fault     = fault_r;
  assign o_fault_tag = fault_tag_r;
  assign o_ccr       = ccr_r;
  assign o_busy      = busy_r;

endmodule

// [tb/fct_dp_model.sv]
// Arithmetic datapath model standing behind the coprocessor issue block.
// Assumes it shares i_clk with the block; it answers every issue exactly on time.
`timescale 1ns/10ps
module fct_dp_model
  import fct_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire fct_pkg::fct_ex_t i_ex,
  input  wire logic [7:0]     i_bad_tag,
  input  wire logic [1:0]     i_bad_kind,
  output fct_pkg::fct_ret_t   o_ret
);
  import fct_pkg::*;
  typedef struct {int due; fct_ret_t r;} fct_slot_t;
  fct_slot_t q[$];
  fct_slot_t s;
  int        cyc;
  int        lat;
  // Answer sampled at issue edge plus latency minus one.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q.delete();
      cyc = 0;
      o_ret <= '0;
    end else begin
      cyc = cyc + 1;
      if (i_ex.valid === 1'b1) begin
        case (i_ex.op)
          FCT_OP_MULD:  lat = i_ex.dbl ? 5 : 4;
          FCT_OP_RECIP: lat = i_ex.dbl ? 26 : 13;
          FCT_OP_RSQRT: lat = i_ex.dbl ? 36 : 17;
          FCT_OP_DIVSQ: lat = i_ex.dbl ? 32 : 17;
          default:      lat = 4;
        endcase
        s.r = '0;
        s.r.valid = 1'b1;
        s.r.is_cmp = (i_ex.op == FCT_OP_CMP);
        s.r.dbl = i_ex.dbl;
        s.r.dst = i_ex.dst;
        s.r.data = i_ex.a + i_ex.b;
        s.r.tag = i_ex.tag;
        s.r.except = (i_ex.tag == i_bad_tag) && (i_bad_kind == 2'h1);
        s.r.denorm = (i_ex.tag == i_bad_tag) && (i_bad_kind == 2'h2);
        s.due = cyc + lat - 3;
        q.push_back(s);
      end
      if (q.size() > 0 && q[0].due == cyc) begin
        s = q.pop_front();
        o_ret <= s.r;
      end else begin
        o_ret <= '0;
      end
    end
  end
endmodule

// [tb/fct_core_monitor.sv]
// Concurrent checks on the ports of the coprocessor issue block.
// Assumes a single clock and the asynchronous high reset of the block.
`timescale 1ns/10ps
module fct_core_chk
  import fct_pkg::*;
(
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire logic                   o_req_ready,
  input wire logic                   i_fault_clear,
  input wire fct_pkg::fct_ret_t      i_ret,
  input wire fct_pkg::fct_ex_t       o_ex,
  input wire logic                   o_fault,
  input wire logic [7:0]             o_fault_tag,
  input wire logic [8:0]             o_ccr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic div_s, rcp_s, mul_d, ftz;
  assign div_s = o_ex.valid && o_ex.op == FCT_OP_DIVSQ && !o_ex.dbl;
  assign rcp_s = o_ex.valid && o_ex.op == FCT_OP_RECIP && !o_ex.dbl;
  assign mul_d = o_ex.valid && o_ex.op == FCT_OP_MULD && o_ex.dbl;
  assign ftz = o_ccr[FCT_CCR_FTZ_BIT];
  sequence s_no_div; (!div_s)[*8]; endsequence
  sequence s_no_rcp; (!rcp_s)[*8]; endsequence
  sequence s_bad_ret; i_ret.valid && i_ret.except && !o_fault; endsequence
  a_fault_blocks: assert property (o_fault |-> !o_req_ready) else $error("ready while faulted");
  a_fault_sticks: assert property (o_fault && !i_fault_clear |=> o_fault) else $error("fault dropped");
  a_fault_tag_set: assert property (s_bad_ret |=> o_fault && o_fault_tag == $past(i_ret.tag))
    else $error("fault not raised with its tag");
  a_denorm_fault: assert property (i_ret.valid && i_ret.denorm && !ftz && !o_fault |=> o_fault)
    else $error("denormal without flush did not fault");
  a_flush_quiet: assert property (i_ret.valid && i_ret.denorm && !i_ret.except && ftz && !o_fault |=> !o_fault)
    else $error("flushed denormal faulted");
  a_muld_rep: assert property (mul_d |=> !mul_d) else $error("double multiply issued too soon");
  a_div_rep: assert property (div_s |=> s_no_div) else $error("divide issued too soon");
  a_recip_rep: assert property (rcp_s |=> s_no_rcp) else $error("reciprocal issued too soon");
endmodule
bind fct_core fct_core_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .o_req_ready(o_req_ready),
  .i_fault_clear(i_fault_clear), .i_ret(i_ret), .o_ex(o_ex), .o_fault(o_fault),
  .o_fault_tag(o_fault_tag), .o_ccr(o_ccr));

// [tb/fct_core_tb_top.sv]
// Self-checking bench for the coprocessor issue block with the datapath model.
// Assumes 250 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/10ps
module fct_core_tb_top;
  import fct_pkg::*;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0, i_fault_clear = 1'b0, fr64 = 1'b1;
  fct_req_t    i_req = '0;
  fct_ret_t    ret;
  fct_ex_t     ex;
  logic        rdy, out_v, flt, busy;
  logic [63:0] out_d, st_d;
  logic [7:0]  out_t, flt_t, st_t, bad_tag = 8'h33;
  logic [8:0]  ccr;
  logic [1:0]  bad_kind = 2'h0;
  int          error_cnt = 0, n_tests = 0, cyc = 0;
  int          exq[$];
  always #2 i_clk = ~i_clk;
  fct_core DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(rdy),
    .i_fr64(fr64), .i_fault_clear(i_fault_clear), .i_ret(ret), .o_ex(ex), .o_out_valid(out_v),
    .o_out_data(out_d), .o_out_tag(out_t), .o_fault(flt), .o_fault_tag(flt_t), .o_ccr(ccr), .o_busy(busy));
  fct_dp_model u_dp (.i_clk(i_clk), .i_rst(i_rst), .i_ex(ex), .i_bad_tag(bad_tag), .i_bad_kind(bad_kind),
    .o_ret(ret));
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (ex.valid === 1'b1) exq.push_back(cyc);
    if (out_v === 1'b1) begin
      st_d <= out_d;
      st_t <= out_t;
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (e !== g) begin
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
      error_cnt++;
    end
  endtask
  function automatic int gapq();
    return (exq.size() > 1) ? exq[1] - exq[0] : 0;
  endfunction
  // Request is held until the edge that finds ready high; valid stays up for back-to-back use.
  task automatic send(input fct_op_t op, input logic d, input logic [4:0] r, input logic [4:0] s,
                      input logic [63:0] v, input logic [7:0] t);
    logic ok;
    i_req_valid = 1'b1;
    i_req = '{op:op, func:6'h00, dbl:d, dst:r, src_a:s, src_b:s, src_c:s, cc_sel:3'h0, ival:v, tag:t};
    for (int k = 0; k < 100; k++) begin
      ok = rdy;
      @(posedge i_clk);
      #1;
      if (ok === 1'b1) return;
    end
    chk("req_taken", 1, 0);
    close_out();
  endtask
  task automatic drain();
    i_req_valid = 1'b0;
    repeat (3) @(posedge i_clk);
    for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge i_clk);
    #1;
    if (busy !== 1'b0) begin
      chk("busy", 0, 1);
      close_out();
    end
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic t_chain();
    send(FCT_OP_LOAD, 1'b0, 5'h01, 5'h01, 64'h10, 8'h10);
    exq.delete();
    send(FCT_OP_ARITH, 1'b0, 5'h03, 5'h01, 64'h0, 8'h11);
    send(FCT_OP_ARITH, 1'b0, 5'h04, 5'h03, 64'h0, 8'h12);
    send(FCT_OP_STORE, 1'b0, 5'h04, 5'h04, 64'h0, 8'h13);
    drain();
    chk("dep_gap", 4, gapq());
    chk("store_data", 64'h40, st_d);
    chk("store_tag", 8'h13, st_t);
    $display("test chain done");
  endtask
  task automatic t_gap(input fct_op_t op, input logic d, input int e);
    exq.delete();
    send(op, d, 5'h05, 5'h01, 64'h0, 8'h01);
    send(op, d, 5'h06, 5'h01, 64'h0, 8'h02);
    drain();
    chk("issue_gap", e, gapq());
    $display("test gap %s done", op.name());
  endtask
  // Pass 0 faults a denormal, pass 1 flushes it, pass 2 faults on an exception.
  task automatic t_fault();
    for (int k = 0; k < 3; k++) begin
      bad_kind = 2'h0;
      send(FCT_OP_CTRL_WR, 1'b0, 5'h00, 5'h01, (k == 1) ? 64'h100 : 64'h0, 8'h20);
      drain();
      chk("ccr", (k == 1) ? 9'h100 : 9'h000, ccr);
      bad_kind = (k == 2) ? 2'h1 : 2'h2;
      send(FCT_OP_ARITH, 1'b0, 5'h08, 5'h01, 64'h0, 8'h33);
      drain();
      chk("fault", (k != 1), flt);
      if (k != 1) chk("fault_tag", 8'h33, flt_t);
      chk("ready", (k == 1), rdy);
      i_fault_clear = 1'b1;
      @(posedge i_clk);
      #1;
      i_fault_clear = 1'b0;
      @(posedge i_clk);
      #1;
      chk("fault_clear", 0, flt);
    end
    $display("test fault done");
  endtask
  task automatic t_pair();
    fr64 = 1'b0;
    drain();
    send(FCT_OP_LOAD, 1'b1, 5'h02, 5'h02, 64'h1122334455667788, 8'h40);
    send(FCT_OP_STORE, 1'b1, 5'h02, 5'h02, 64'h0, 8'h41);
    drain();
    chk("pair_data", 64'h1122334455667788, st_d);
    send(FCT_OP_STORE, 1'b0, 5'h03, 5'h03, 64'h0, 8'h42);
    drain();
    chk("pair_hi", 32'h11223344, st_d[31:0]);
    $display("test pair done");
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("ready_rst", 1, rdy);
    chk("ccr_rst", 0, ccr);
    chk("fault_rst", 0, flt);
    t_chain();
    t_gap(FCT_OP_ARITH, 1'b0, 1);
    t_gap(FCT_OP_MULD, 1'b0, 1);
    t_gap(FCT_OP_MULD, 1'b1, FCT_REP_MULD);
    t_gap(FCT_OP_RECIP, 1'b0, FCT_REP_RCP_S);
    t_gap(FCT_OP_RECIP, 1'b1, FCT_REP_RCP_D);
    t_gap(FCT_OP_RSQRT, 1'b0, FCT_REP_RSQ_S);
    t_gap(FCT_OP_RSQRT, 1'b1, FCT_REP_RSQ_D);
    t_gap(FCT_OP_DIVSQ, 1'b0, FCT_REP_DIV_S);
    t_gap(FCT_OP_DIVSQ, 1'b1, FCT_REP_DIV_D);
    t_fault();
    t_pair();
    close_out();
  end
endmodule
